// ==== hw/clkdiv_pkg.sv ====
// Purpose: shared constants and types for the clock divider and fanout control block
// Assumes: one system clock; every pin input is synchronised before use
// Notes: the single control register has no pointer byte on the serial port
package clkdiv_pkg;
  localparam int NUM_OUTS = 8;
  localparam int DIV_SEL_W = 2;
  localparam int DIV_CNT_W = 4;
  localparam int SYNC_W = 7;
  // positions inside the synchronised pin bundle
  localparam int SY_REF = 6;
  localparam int SY_SCL = 5;
  localparam int SY_SDA = 4;
  localparam int SY_SEL_HI = 3;
  localparam int SY_SEL_LO = 2;
  localparam int SY_ADR_HI = 1;
  localparam int SY_ADR_LO = 0;
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [4:0] ADDR_PREFIX = 5'h1A;
  localparam int RW_POS = 0;
  localparam int MSB_POS = 7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] CNT_ZERO = 4'h0;
  localparam logic [3:0] CNT_ONE = 4'h1;
  localparam logic [1:0] SEL_DIV1 = 2'h0;
  localparam logic [1:0] SEL_DIV2 = 2'h1;
  localparam logic [1:0] SEL_DIV8 = 2'h3;
  typedef enum logic [2:0] {
    st_idle,
    st_addr,
    st_addr_ack,
    st_wr_data,
    st_wr_ack,
    st_rd_data,
    st_rd_ack,
    st_ignore
  } i2c_state_t;
endpackage

// ==== hw/pin_sync.sv ====
// Purpose: two-stage synchroniser for every pin input of the block
// Assumes: inputs are levels from outside the clk_sys domain
// Notes: the first stage feeds only the second stage
`timescale 1ns/1ps
module pin_sync
  import clkdiv_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [SYNC_W-1:0] async_in,
  output logic [SYNC_W-1:0] sync_out
);
  logic [SYNC_W-1:0] meta;

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // pin_sync

// ==== hw/ref_divider.sv ====
// Purpose: divides the synchronised reference by 1, 2, 4 or 8
// Assumes: reference input already synchronised to clk_sys
// Notes: each reference edge advances the counter, so bit 0 runs at the reference rate
`timescale 1ns/1ps
module ref_divider
  import clkdiv_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ref_lvl,
  input wire logic [DIV_SEL_W-1:0] div_sel,
  output logic div_clk
);
  logic ref_q;
  logic [DIV_CNT_W-1:0] cnt;
  wire ref_edge = ref_lvl ^ ref_q;
  // tap picked straight from the select, no wait for a counter boundary
  wire tap = cnt[div_sel];

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      ref_q <= 1'b0;
      cnt <= '0;
      div_clk <= 1'b0;
    end
    else
    begin
      ref_q <= ref_lvl;
      if (ref_edge)
        cnt <= cnt + 4'h1;
      div_clk <= tap;
    end
  end

  a_div_one_rate: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ref_edge && div_sel == SEL_DIV1) ##1 (div_sel == SEL_DIV1) |-> ##1 (div_clk != $past(div_clk)))
    else $error("divide by one output missed a reference edge");
  a_div_two_rate: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ref_edge && cnt[0] && div_sel == SEL_DIV2) ##1 (div_sel == SEL_DIV2)
    |-> ##1 (div_clk != $past(div_clk)))
    else $error("divide by two output did not toggle");
  a_div_eight_rate: assert property (@(posedge clk_sys) disable iff (!rstn)
    (ref_edge && cnt[2:0] == 3'h7 && div_sel == SEL_DIV8) ##1 (div_sel == SEL_DIV8)
    |-> ##1 (div_clk != $past(div_clk)))
    else $error("divide by eight output did not toggle");
  a_sel_immediate: assert property (@(posedge clk_sys) disable iff (!rstn)
    ($changed(div_sel) && !ref_edge) |=> (div_clk == cnt[$past(div_sel)]))
    else $error("new divide select did not act at once");
endmodule // ref_divider

// ==== hw/clock_divider_fanout_ctrl.sv ====
// Purpose: divider, eight-pair fanout with per-pair disable and a serial target port
// Assumes: scl below a tenth of the clk_sys rate; pins synchronised before use
// Notes: single byte register; extra bytes in a write are ignored without ack
`timescale 1ns/1ps
module clock_divider_fanout_ctrl
  import clkdiv_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic ref_clk_in,
  input wire logic divide_select_hi,
  input wire logic divide_select_lo,
  input wire logic addr_strap_hi,
  input wire logic addr_strap_lo,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  output logic [NUM_OUTS-1:0] clock_out_p,
  output logic [NUM_OUTS-1:0] clock_out_n,
  output logic [NUM_OUTS-1:0] clock_out_oe_n
);
  import clkdiv_pkg::*;

  logic [SYNC_W-1:0] pins_s;
  logic div_clk;
  logic scl_q;
  logic sda_q;
  i2c_state_t state;
  i2c_state_t next_state;
  logic [3:0] bit_cnt;
  logic [3:0] next_cnt;
  logic [7:0] shift_reg;
  logic [7:0] next_shift;
  logic [7:0] tx_reg;
  logic [7:0] next_tx;
  logic next_oe_n;
  logic write_commit;
  logic [7:0] output_tristate_ctrl;
  logic first_write_done;

  // pin synchronisation, one bundle
  pin_sync u_sync (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .async_in({ref_clk_in, scl_in, sda_in, divide_select_hi, divide_select_lo,
               addr_strap_hi, addr_strap_lo}),
    .sync_out(pins_s)
  );

  wire scl_s = pins_s[SY_SCL];
  wire sda_s = pins_s[SY_SDA];
  wire [DIV_SEL_W-1:0] divide_select = {pins_s[SY_SEL_HI], pins_s[SY_SEL_LO]};

  ref_divider u_div (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ref_lvl(pins_s[SY_REF]),
    .div_sel(divide_select),
    .div_clk(div_clk)
  );

  // bus condition decode
  wire scl_rise = scl_s & ~scl_q;
  wire scl_fall = ~scl_s & scl_q;
  wire start_det = scl_s & scl_q & sda_q & ~sda_s;
  wire stop_det = scl_s & scl_q & ~sda_q & sda_s;
  wire [6:0] target_address = {ADDR_PREFIX, pins_s[SY_ADR_HI], pins_s[SY_ADR_LO]};
  wire addr_hit = shift_reg[7:1] == target_address;
  wire rw_bit = shift_reg[RW_POS];
  wire byte_done = bit_cnt == BYTE_BITS;
  wire rx_state = state == st_addr || state == st_wr_data ||
                  state == st_rd_data || state == st_rd_ack;
  wire master_ack = ~shift_reg[0];
  // before the first write the pairs stay enabled whatever the register holds
  wire [7:0] eff_disable = first_write_done ? output_tristate_ctrl : CTRL_RESET;

  always_comb
  begin
    next_state = state;
    next_cnt = bit_cnt;
    next_shift = shift_reg;
    next_tx = tx_reg;
    next_oe_n = sda_oe_n;
    write_commit = 1'b0;
    if (stop_det)
    begin
      next_state = st_idle;
      next_oe_n = 1'b1;
    end
    else if (start_det)
    begin
      // start or repeated start from any state
      next_state = st_addr;
      next_cnt = CNT_ZERO;
      next_oe_n = 1'b1;
    end
    else if (scl_rise && rx_state)
    begin
      // sample on the high phase, where sda is stable
      next_shift = {shift_reg[6:0], sda_s};
      next_cnt = bit_cnt + CNT_ONE;
    end
    else if (scl_fall)
    begin
      unique case (state)
        st_idle:
        begin
          next_state = st_idle;
        end
        st_addr:
        begin
          if (byte_done)
          begin
            if (addr_hit)
            begin
              next_state = st_addr_ack;
              next_oe_n = 1'b0;
            end
            else
              next_state = st_ignore;
          end
        end
        st_addr_ack:
        begin
          next_cnt = CNT_ZERO;
          if (rw_bit)
          begin
            next_state = st_rd_data;
            next_tx = output_tristate_ctrl;
            next_oe_n = output_tristate_ctrl[MSB_POS];
          end
          else
          begin
            next_state = st_wr_data;
            next_oe_n = 1'b1;
          end
        end
        st_wr_data:
        begin
          if (byte_done)
          begin
            write_commit = 1'b1;
            next_state = st_wr_ack;
            next_oe_n = 1'b0;
          end
        end
        st_wr_ack:
        begin
          next_state = st_ignore;
          next_oe_n = 1'b1;
        end
        st_rd_data:
        begin
          if (byte_done)
          begin
            next_state = st_rd_ack;
            next_cnt = CNT_ZERO;
            next_oe_n = 1'b1;
          end
          else
          begin
            // next bit goes out while scl is low
            next_tx = {tx_reg[6:0], 1'b0};
            next_oe_n = tx_reg[MSB_POS-1];
          end
        end
        st_rd_ack:
        begin
          if (master_ack)
          begin
            next_state = st_rd_data;
            next_cnt = CNT_ZERO;
            next_tx = output_tristate_ctrl;
            next_oe_n = output_tristate_ctrl[MSB_POS];
          end
          else
            next_state = st_ignore;
        end
        st_ignore:
        begin
          next_state = st_ignore;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      state <= st_idle;
      bit_cnt <= CNT_ZERO;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      sda_oe_n <= 1'b1;
      sda_out <= 1'b0;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
      state <= next_state;
      bit_cnt <= next_cnt;
      shift_reg <= next_shift;
      tx_reg <= next_tx;
      sda_oe_n <= next_oe_n;
      sda_out <= 1'b0;
    end
  end

  // control register, cleared only by the power-up reset
  always_ff @(posedge clk_sys or negedge rstn)
  begin
    if (!rstn)
    begin
      output_tristate_ctrl <= CTRL_RESET;
      first_write_done <= 1'b0;
    end
    else if (write_commit)
    begin
      output_tristate_ctrl <= shift_reg;
      first_write_done <= 1'b1;
    end
  end

  // output stage, one pair per control bit; disable acts without a reference edge
  genvar gi;
  generate
    for (gi = 0; gi < NUM_OUTS; gi++)
    begin : g_pair
      always_ff @(posedge clk_sys or negedge rstn)
      begin
        if (!rstn)
        begin
          clock_out_p[gi] <= 1'b0;
          clock_out_n[gi] <= 1'b1;
          clock_out_oe_n[gi] <= 1'b0;
        end
        else
        begin
          clock_out_p[gi] <= div_clk;
          clock_out_n[gi] <= ~div_clk;
          clock_out_oe_n[gi] <= eff_disable[gi];
        end
      end
    end
  endgenerate

  a_pair_disable: assert property (@(posedge clk_sys) disable iff (!rstn)
    write_commit |-> ##2 (clock_out_oe_n == $past(shift_reg, 2)))
    else $error("written disable bits did not reach the output pairs");
  a_pair_follow: assert property (@(posedge clk_sys) disable iff (!rstn)
    first_write_done ##1 first_write_done |-> (clock_out_oe_n == $past(output_tristate_ctrl)))
    else $error("output pair enable does not match its control bit");
  a_enabled_pre_write: assert property (@(posedge clk_sys) disable iff (!rstn)
    (!first_write_done && !$past(first_write_done)) |-> (clock_out_oe_n == 8'h00))
    else $error("an output pair is disabled before the first write");
  a_enable_no_ref: assert property (@(posedge clk_sys) disable iff (!rstn)
    (write_commit && $stable(div_clk)) |-> ##2 (clock_out_oe_n == $past(shift_reg, 2)))
    else $error("enable change waited for a reference edge");
  a_addr_miss: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == st_addr && scl_fall && byte_done && !addr_hit && !start_det && !stop_det)
    |=> (state == st_ignore && sda_oe_n))
    else $error("foreign address was acknowledged");
  a_rw_decode: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == st_addr_ack && scl_fall && !start_det && !stop_det)
    |=> (state == (rw_bit ? st_rd_data : st_wr_data)) || $past(!rw_bit) && state == st_wr_data)
    else $error("read or write not decoded from bit 0");
  a_start_begin: assert property (@(posedge clk_sys) disable iff (!rstn)
    (start_det && !stop_det) |=> (state == st_addr && bit_cnt == CNT_ZERO && sda_oe_n))
    else $error("start condition did not begin an address phase");
  a_stop_end: assert property (@(posedge clk_sys) disable iff (!rstn)
    stop_det |=> (state == st_idle && sda_oe_n))
    else $error("stop condition did not end the transfer");
  a_sda_change_low: assert property (@(posedge clk_sys) disable iff (!rstn)
    $changed(sda_oe_n) |-> ($past(scl_fall) || $past(start_det) || $past(stop_det)))
    else $error("device changed sda outside the scl low phase");
  a_ack_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == st_addr_ack || state == st_wr_ack) |-> !sda_oe_n)
    else $error("acknowledge not held low");
  a_read_msb: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == st_addr_ack && scl_fall && rw_bit && !start_det && !stop_det)
    |=> (sda_oe_n == output_tristate_ctrl[MSB_POS]))
    else $error("read did not start with register bit 7");
  a_write_store: assert property (@(posedge clk_sys) disable iff (!rstn)
    write_commit |=> (output_tristate_ctrl == $past(shift_reg) && state == st_wr_ack))
    else $error("write byte not stored");

  // clock fanout checks
  a_pair_diff: assert property (@(posedge clk_sys) disable iff (!rstn)
    clock_out_n == ~clock_out_p)
    else $error("a pair is not the inverse of its true output");
  a_fanout_equal: assert property (@(posedge clk_sys) disable iff (!rstn)
    clock_out_p == {NUM_OUTS{clock_out_p[0]}})
    else $error("output pairs do not carry one common clock");
  a_pair_tracks: assert property (@(posedge clk_sys) disable iff (!rstn)
    clock_out_p == {NUM_OUTS{$past(div_clk)}})
    else $error("output pairs do not follow the divided clock");

  // serial port checks
  a_addr_ack: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == st_addr && scl_fall && byte_done && addr_hit)
    |=> (state == st_addr_ack && !sda_oe_n))
    else $error("own address was not acknowledged");
  a_write_ack: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == st_wr_data && scl_fall && byte_done) |=> !sda_oe_n)
    else $error("data byte of a write was not acknowledged");
  a_read_next: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == st_rd_data && scl_fall && !byte_done)
    |=> (sda_oe_n == output_tristate_ctrl[MSB_POS - $past(bit_cnt)]))
    else $error("read bit does not match the register");
  a_read_release: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == st_rd_data && scl_fall && byte_done)
    |=> (state == st_rd_ack && sda_oe_n))
    else $error("device did not release sda for the read acknowledge");
  a_nack_end: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == st_rd_ack && scl_fall && !master_ack) |=> (state == st_ignore))
    else $error("not-acknowledge did not end the read");
  a_ack_repeat: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == st_rd_ack && scl_fall && master_ack)
    |=> (state == st_rd_data && sda_oe_n == output_tristate_ctrl[MSB_POS]))
    else $error("acknowledged read did not resend the register");
  a_ignore_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == st_ignore) |-> sda_oe_n)
    else $error("device drove sda while ignoring the bus");
  a_idle_quiet: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == st_idle) |-> sda_oe_n)
    else $error("device drove sda while idle");
  a_wr_ack_end: assert property (@(posedge clk_sys) disable iff (!rstn)
    (state == st_wr_ack && scl_fall) |=> (state == st_ignore && sda_oe_n))
    else $error("write acknowledge was not released");
  a_bit_shift: assert property (@(posedge clk_sys) disable iff (!rstn)
    (scl_rise && rx_state) |=> (shift_reg[0] == $past(sda_s)))
    else $error("sda not sampled at the scl rise");
  // register checks
  a_reg_hold: assert property (@(posedge clk_sys) disable iff (!rstn)
    !write_commit |=> $stable(output_tristate_ctrl))
    else $error("control register changed without a write");
  a_bit_range: assert property (@(posedge clk_sys) disable iff (!rstn)
    bit_cnt <= BYTE_BITS)
    else $error("bit counter ran past one byte");
endmodule // clock_divider_fanout_ctrl

// ==== verif/i2c_ctrl_model.sv ====
// Purpose: behavioural serial bus controller facing the target port
// Assumes: open-drain data line with a pull-up, resolved by the bench
// Notes: each ack bit or received byte is reported as one result pulse
`timescale 1ns/1ps
module i2c_ctrl_model
(
  input wire logic clk_sys,
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  output logic res_valid,
  output logic [7:0] res_val
);
  localparam int HALF = 6;
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
    res_valid = 1'b0;
    res_val = 8'h00;
  end
  task automatic hold();
    repeat (HALF) @(negedge clk_sys);
  endtask
  task automatic report(input logic [7:0] v);
    res_val = v;
    res_valid = 1'b1;
    @(negedge clk_sys);
    res_valid = 1'b0;
  endtask
  task automatic start();
    sda_low = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b1;
    hold();
    scl = 1'b0;
  endtask
  task automatic stop();
    sda_low = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    sda_low = 1'b0;
    hold();
  endtask
  // data moves only in the low phase, one clock after scl falls
  task automatic bit_io(input logic b, output logic s);
    @(negedge clk_sys);
    sda_low = ~b;
    hold();
    scl = 1'b1;
    hold();
    s = sda;
    scl = 1'b0;
  endtask
  task automatic tx(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, s);
    report({7'h00, s});
  endtask
  task automatic rx(input logic more);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(~more, s);
    report(d);
  endtask
endmodule // i2c_ctrl_model

// ==== verif/tb.sv ====
// Purpose: self-checking bench for the divider and fanout control block
// Assumes: the controller model drives the serial port
// Notes: expected bus results are queued and matched as they appear
`timescale 1ns/1ps
module tb;
  import clkdiv_pkg::*;
  logic clk_sys = 1'b0;
  logic rstn = 1'b0;
  logic ref_clk_in = 1'b0;
  logic ref_run = 1'b1;
  logic divide_select_hi = 1'b0;
  logic divide_select_lo = 1'b0;
  logic addr_strap_hi = 1'b0;
  logic addr_strap_lo = 1'b0;
  logic scl, sda_low, sda_out, sda_oe_n, res_valid, scl_q, oe_q;
  logic [7:0] res_val, wd;
  logic [NUM_OUTS-1:0] clock_out_p, clock_out_n, clock_out_oe_n;
  logic [6:0] own;
  logic [7:0] exp_q[$];
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  int seed = 66;
  wire sda = ~sda_low & (sda_oe_n ? 1'b1 : sda_out);
  initial
    forever #50 clk_sys = ~clk_sys;
  always
  begin
    repeat (4) @(negedge clk_sys);
    if (ref_run)
      ref_clk_in = ~ref_clk_in;
  end
  clock_divider_fanout_ctrl i_clock_divider_fanout_ctrl (.clk_sys(clk_sys), .rstn(rstn),
    .ref_clk_in(ref_clk_in), .divide_select_hi(divide_select_hi),
    .divide_select_lo(divide_select_lo), .addr_strap_hi(addr_strap_hi),
    .addr_strap_lo(addr_strap_lo), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe_n(sda_oe_n), .clock_out_p(clock_out_p), .clock_out_n(clock_out_n),
    .clock_out_oe_n(clock_out_oe_n));
  i2c_ctrl_model i_i2c_ctrl_model (.clk_sys(clk_sys), .sda(sda), .scl(scl),
    .sda_low(sda_low), .res_valid(res_valid), .res_val(res_val));
  task automatic chk_val(input string nm, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e)
    begin
      err_total++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_bus(input logic [7:0] g);
    if (exp_q.size() == 0)
      chk_val("bus_extra", 8'h00, 8'hXX);
    else
      chk_val("bus", exp_q.pop_front(), g);
  endtask
  task automatic final_report();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk_sys)
  begin
    if (res_valid === 1'b1)
      chk_bus(res_val);
    if (scl && scl_q && rstn)
      chk_val("sda_hold", {7'h00, oe_q}, {7'h00, sda_oe_n});
    scl_q <= scl;
    oe_q <= sda_oe_n;
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      err_total++;
      final_report();
    end
  end
  task automatic wr(input logic [6:0] a, input logic [7:0] d, input logic stp);
    exp_q.push_back({7'h00, a != own});
    exp_q.push_back({7'h00, a != own});
    i_i2c_ctrl_model.start();
    i_i2c_ctrl_model.tx({a, 1'b0});
    i_i2c_ctrl_model.tx(d);
    if (stp)
      i_i2c_ctrl_model.stop();
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] d, input logic two = 1'b0);
    exp_q.push_back({7'h00, a != own});
    exp_q.push_back(a == own ? d : 8'hFF);
    if (two)
      exp_q.push_back(d);
    i_i2c_ctrl_model.start();
    i_i2c_ctrl_model.tx({a, 1'b1});
    if (two)
      i_i2c_ctrl_model.rx(1'b1);
    i_i2c_ctrl_model.rx(1'b0);
    i_i2c_ctrl_model.stop();
  endtask
  task automatic meas(input logic [1:0] code);
    int n;
    n = 0;
    {divide_select_hi, divide_select_lo} = code;
    repeat (80) @(negedge clk_sys);
    while (clock_out_p[0] !== 1'b1)
      @(negedge clk_sys);
    do
    begin
      @(negedge clk_sys);
      n++;
    end while (clock_out_p[0] !== 1'b0);
    while (clock_out_p[0] !== 1'b1)
    begin
      @(negedge clk_sys);
      n++;
    end
    chk_val("period", 8'(8 << code), 8'(n));
    chk_val("pair", ~clock_out_p, clock_out_n);
    chk_val("fan", {8{clock_out_p[0]}}, clock_out_p);
  endtask
  task automatic do_reset();
    rstn = 1'b0;
    repeat (16) @(negedge clk_sys);
    rstn = 1'b1;
    repeat (10) @(negedge clk_sys);
    chk_val("oe_rst", CTRL_RESET, clock_out_oe_n);
    chk_val("sda_rel", 8'h01, {7'h00, sda_oe_n});
    chk_val("sda_drv", 8'h00, {7'h00, sda_out});
  endtask
  initial
  begin
    {addr_strap_hi, addr_strap_lo} = 2'($random(seed));
    own = {ADDR_PREFIX, addr_strap_hi, addr_strap_lo};
    do_reset();
    for (int c = 3; c >= 0; c--)
      meas(2'(c));
    ref_run = 1'b0;
    rd(own, 8'h00);
    for (int k = 0; k < 3; k++)
    begin
      wd = 8'($random(seed));
      wr(own, wd, 1'b1);
      repeat (8) @(negedge clk_sys);
      chk_val("oe", wd, clock_out_oe_n);
      rd(own, wd);
    end
    wr({ADDR_PREFIX, ~own[1:0]}, 8'hA5, 1'b1);
    rd({5'h0A, own[1:0]}, 8'h00);
    chk_val("oe_kept", wd, clock_out_oe_n);
    wr(own, 8'h3C, 1'b0);
    rd(own, 8'h3C);
    chk_val("oe", 8'h3C, clock_out_oe_n);
    rd(own, 8'h3C, 1'b1);
    do_reset();
    rd(own, CTRL_RESET);
    repeat (4) @(negedge clk_sys);
    chk_val("queue", 8'h00, 8'(exp_q.size()));
    final_report();
  end
endmodule // tb
